// >>> rtl/tbrc_params.svh
// constants for the trace buffer readout and line counter
`ifndef TBRC_PARAMS_SVH
`define TBRC_PARAMS_SVH
// register byte addresses (8-bit address, 16-bit data register bus)
`define TBRC_ADDR_CTRL1 8'h20
`define TBRC_ADDR_STATUS 8'h21
`define TBRC_ADDR_TRCCTL 8'h22
`define TBRC_ADDR_WIN_HI 8'h24
`define TBRC_ADDR_WIN_LO 8'h25
`define TBRC_ADDR_COUNT 8'h26
`define TBRC_ADDR_BANKED 8'h27
`define TBRC_ADDR_CAPTURE 8'h28
// field positions
`define TBRC_BIT_ARM 7
`define TBRC_BIT_TSRC 6
`define TBRC_BIT_TALIGN 0
`define TBRC_BIT_FULL 7
`define TBRC_SEL_LO 0
// values
`define TBRC_SSF_IDLE 3'h0
`define TBRC_SSF_ONE 3'h1
`define TBRC_SEL_MATCH 2'h3
`define TBRC_ZERO8 8'h00
`define TBRC_ZERO16 16'h0000
`define TBRC_CNT_ONE 6'h01
`define TBRC_CNT_LAST 6'h3F
`endif

// >>> rtl/tbrc_pkg.sv
// types shared by the trace buffer readout files
package tbrc_pkg;
    // one register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
        logic word;
    } tbrc_req_s;
    // one captured trace line
    typedef struct packed {
        logic valid;
        logic [19:0] data;
    } tbrc_line_s;
    // buffer lock states
    typedef enum logic [1:0] {
        TBRC_LOCKED = 2'b00,
        TBRC_OPEN = 2'b01
    } tbrc_lock_e;
endpackage : tbrc_pkg

// >>> rtl/tbrc_trace_ram.sv
// trace line storage, written by capture, read by the window
`timescale 1ns/1ps
`include "tbrc_params.svh"
module tbrc_trace_ram import tbrc_pkg::*; #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // clock
    input wire logic core_clk,
    // write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [19:0] wr_data,
    // read side
    input wire logic [AW-1:0] rd_addr,
    output logic [19:0] rd_data
);
    // no reset on storage: contents survive every reset
    logic [19:0] mem [DEPTH];
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
    // asynchronous read, the top registers the result
    assign rd_data = mem[rd_addr];
endmodule : tbrc_trace_ram

// >>> rtl/tbrc_top.sv
// trace buffer readout window, line counter and banked state controls
//
// Behaviour
// [RQ1] data only unlocked, unsecured, disarmed, source set
// [RQ2] disarmed aligned word write unlocks, keeps data
// [RQ3] 20-bit lines read through 16-bit window
// [RQ4] each valid read advances read pointer
// [RQ5] arming locks buffer until disarmed unlock
// [RQ6] byte or misaligned reads give zero
// [RQ7] armed or source-clear reads give zero
// [RQ8] contents kept over non-power-on resets
// [RQ9] full flag after 64 lines since arming
// [RQ10] arming or power-on clears full flag
// [RQ11] arming or power-on clears count
// [RQ12] full flag at bit 7 of count, status
// [RQ13] six-bit count in bits 5 to 0
// [RQ14] count wrap sets full, keeps counting
// [RQ15] begin alignment: 64 lines ends session
// [RQ16] full with nonzero count means overwritten
// [RQ17] reads never decrement the count
// [RQ18] state controls share one banked address
// [RQ19] select 00/01/10 states, 11 match flags
// [RQ20] each state owns its control register
// [RQ21] arming enters state 1, flags 001
// [RQ22] source bit cannot be set when secured
// [RQ23] unlock restarts pointer at oldest line
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "tbrc_params.svh"
module tbrc_top import tbrc_pkg::*; #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // clock and resets
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic por_rst,
    // register bus
    input wire logic [7:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_word,
    output logic [15:0] bus_rdata,
    // capture side and security
    input wire logic cap_valid,
    input wire logic [19:0] cap_data,
    input wire logic [3:0] match_flags,
    input wire logic secured,
    // status outputs
    output logic armed,
    output logic [2:0] seq_state_flags
);
    // ********************************************************
    // request decode
    // ********************************************************
    tbrc_req_s req; // bundled bus request
    assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd,
                   word: bus_word};

    // address match helper, used by several decodes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    logic [7:0] ctrl_one; // debug_control_one: arm, bank select
    logic trace_source_select; // trace source enable
    logic trig_align; // 1 = begin alignment
    logic [3:0] state_ctl [3]; // state_one..three_control
    logic [AW-1:0] wr_ptr; // next capture slot
    logic [AW-1:0] rd_ptr; // next line to read
    logic [5:0] valid_line_field; // stored-line count
    logic buffer_full_flag; // 64 or more since arming
    tbrc_lock_e lock_st; // window lock
    logic [19:0] ram_q; // addressed line
    logic [3:0] hold_hi; // upper four bits held for a read of the capture address
    logic [1:0] bank_select_field;
    logic arm_write; // software writes one to arm
    logic unlock_write; // aligned disarmed window write
    logic win_read_ok; // valid window read
    logic cap_we; // line actually stored

    assign bank_select_field = ctrl_one[1:0];
    assign arm_write = req.wr && hit(req.addr, `TBRC_ADDR_CTRL1) && req.wdata[`TBRC_BIT_ARM];
    // only word access to the even address counts as aligned
    assign unlock_write = req.wr && req.word && hit(req.addr, `TBRC_ADDR_WIN_HI) && !armed; // see [RQ2]
    // gated fully: lock, security, arm state and source bit
    assign win_read_ok = req.rd && req.word && hit(req.addr, `TBRC_ADDR_WIN_HI) // see [RQ6]
                         && lock_st == TBRC_OPEN && !secured && !armed // see [RQ1] see [RQ7]
                         && trace_source_select;
    assign cap_we = cap_valid && armed && trace_source_select;

    // ********************************************************
    // control registers: ctrl_one reset by power-on, armed and trace control by system reset
    // ********************************************************
    // arm and bank select, cleared only by power-on
    always_ff @(posedge core_clk or posedge por_rst) begin
        if (por_rst) begin
            ctrl_one <= `TBRC_ZERO8;
        end else if (req.wr && hit(req.addr, `TBRC_ADDR_CTRL1)) begin
            ctrl_one <= req.wdata[7:0];
        end
    end

    // armed flag: set by write, cleared by begin-aligned fill
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            armed <= 1'b0;
        end else if (arm_write) begin
            armed <= 1'b1;
        end else if (req.wr && hit(req.addr, `TBRC_ADDR_CTRL1)) begin
            armed <= 1'b0; // software disarm
        end else if (cap_we && trig_align && valid_line_field == `TBRC_CNT_LAST) begin
            armed <= 1'b0; // 64th line in begin alignment, see [RQ15]
        end
    end

    // trace control: source bit refused while secured or armed
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trace_source_select <= 1'b0;
            trig_align <= 1'b0;
        end else if (req.wr && hit(req.addr, `TBRC_ADDR_TRCCTL) && !armed) begin
            trace_source_select <= req.wdata[`TBRC_BIT_TSRC] && !secured; // see [RQ22]
            trig_align <= req.wdata[`TBRC_BIT_TALIGN];
        end else if (secured) begin
            trace_source_select <= 1'b0; // see [RQ22]
        end
    end

    // ********************************************************
    // banked state control registers
    // ********************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sc
            // one register per sequencer state, written only disarmed
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    state_ctl[gi] <= 4'h0;
                end else if (req.wr && hit(req.addr, `TBRC_ADDR_BANKED) && !armed
                             && bank_select_field == 2'(gi)) begin
                    state_ctl[gi] <= req.wdata[3:0]; // see [RQ18] see [RQ20]
                end
            end
        end
    endgenerate

    // sequencer flags: arming forces state one
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_state_flags <= `TBRC_SSF_IDLE;
        end else if (arm_write) begin
            seq_state_flags <= `TBRC_SSF_ONE; // see [RQ21]
        end else if (cap_we && trig_align && valid_line_field == `TBRC_CNT_LAST) begin
            seq_state_flags <= `TBRC_SSF_IDLE; // internal end returns to idle
        end
    end

    // ********************************************************
    // count and full flag, power-on reset only
    // ********************************************************
    // count survives system resets so software sees pre-reset lines
    always_ff @(posedge core_clk or posedge por_rst) begin
        if (por_rst) begin
            valid_line_field <= 6'h00; // see [RQ11]
            buffer_full_flag <= 1'b0; // see [RQ10]
        end else if (arm_write) begin
            valid_line_field <= 6'h00; // see [RQ11]
            buffer_full_flag <= 1'b0; // see [RQ10]
        end else if (cap_we) begin
            // keeps counting past wrap; reads never touch it, see [RQ14] see [RQ17]
            valid_line_field <= valid_line_field + `TBRC_CNT_ONE; // see [RQ13]
            if (valid_line_field == `TBRC_CNT_LAST) begin
                buffer_full_flag <= 1'b1; // see [RQ9] see [RQ14] see [RQ16]
            end
        end
    end

    // capture write pointer, wraps so newest overwrites oldest
    always_ff @(posedge core_clk or posedge por_rst) begin
        if (por_rst) begin
            wr_ptr <= '0;
        end else if (arm_write) begin
            wr_ptr <= '0;
        end else if (cap_we) begin
            wr_ptr <= wr_ptr + AW'(1); // see [RQ16]
        end
    end

    // ********************************************************
    // lock and read pointer
    // ********************************************************
    // arming locks; disarmed aligned write unlocks
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_st <= TBRC_LOCKED;
        end else if (arm_write) begin
            lock_st <= TBRC_LOCKED; // see [RQ5]
        end else if (unlock_write) begin
            lock_st <= TBRC_OPEN; // see [RQ2] see [RQ5]
        end
    end

    // pointer restarts at oldest valid line on unlock
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_ptr <= '0;
        end else if (unlock_write) begin
            rd_ptr <= buffer_full_flag ? wr_ptr : '0; // see [RQ23]
        end else if (win_read_ok) begin
            rd_ptr <= rd_ptr + AW'(1); // see [RQ4]
        end
    end

    // storage keeps no reset, so only power-on leaves it undefined
    tbrc_trace_ram #(.DEPTH(DEPTH), .AW(AW)) u_ram ( // see [RQ8]
        .core_clk(core_clk),
        .wr_en(cap_we),
        .wr_addr(wr_ptr),
        .wr_data(cap_data),
        .rd_addr(rd_ptr),
        .rd_data(ram_q)
    );

    // ********************************************************
    // read data, one cycle after the strobe
    // ********************************************************
    // top four bits held after a window read, visible at capture address
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_hi <= 4'h0;
        end else if (win_read_ok) begin
            hold_hi <= ram_q[19:16]; // see [RQ3]
        end
    end

    // read mux; unmapped addresses read zero
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata <= `TBRC_ZERO16;
        end else if (req.rd) begin
            bus_rdata <= `TBRC_ZERO16;
            case (req.addr)
                `TBRC_ADDR_WIN_HI: begin
                    if (win_read_ok) begin
                        bus_rdata <= ram_q[15:0]; // see [RQ3] see [RQ6] see [RQ7]
                    end
                end
                `TBRC_ADDR_CTRL1: begin
                    bus_rdata <= {8'h00, armed, ctrl_one[6:0]};
                end
                `TBRC_ADDR_STATUS: begin
                    bus_rdata <= {8'h00, buffer_full_flag, 4'h0, seq_state_flags}; // see [RQ12]
                end
                `TBRC_ADDR_TRCCTL: begin
                    bus_rdata <= {9'h000, trace_source_select, 5'h00, trig_align};
                end
                `TBRC_ADDR_COUNT: begin
                    bus_rdata <= {8'h00, buffer_full_flag, 1'b0, valid_line_field}; // see [RQ12]
                end
                `TBRC_ADDR_BANKED: begin
                    if (bank_select_field == `TBRC_SEL_MATCH) begin
                        bus_rdata <= {12'h000, match_flags}; // see [RQ19]
                    end else begin
                        bus_rdata <= {12'h000, state_ctl[bank_select_field]}; // see [RQ19]
                    end
                end
                `TBRC_ADDR_CAPTURE: begin
                    bus_rdata <= {12'h000, hold_hi};
                end
                default: begin
                    bus_rdata <= `TBRC_ZERO16;
                end
            endcase
        end else begin
            bus_rdata <= `TBRC_ZERO16;
        end
    end

    // ********************************************************
    // assertions
    // ********************************************************
    property p_arm_locks;
        @(posedge core_clk) disable iff (sys_rst || por_rst)
        arm_write |=> lock_st == TBRC_LOCKED && seq_state_flags == `TBRC_SSF_ONE;
    endproperty
    a_arm_locks: assert property (p_arm_locks) else $error("arm did not lock"); // see [RQ5]
    property p_unlock;
        @(posedge core_clk) disable iff (sys_rst || por_rst)
        unlock_write && !arm_write |=> lock_st == TBRC_OPEN;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock failed"); // see [RQ2]
    property p_bad_read_zero;
        @(posedge core_clk) disable iff (sys_rst || por_rst)
        req.rd && hit(req.addr, `TBRC_ADDR_WIN_HI) && (!req.word || armed)
        |=> bus_rdata == `TBRC_ZERO16 && $stable(rd_ptr);
    endproperty
    a_bad_read_zero: assert property (p_bad_read_zero) else $error("bad read"); // see [RQ6]
    property p_src_read_zero;
        @(posedge core_clk) disable iff (sys_rst || por_rst)
        req.rd && hit(req.addr, `TBRC_ADDR_WIN_HI) && !trace_source_select
        |=> bus_rdata == `TBRC_ZERO16;
    endproperty
    a_src_read_zero: assert property (p_src_read_zero) else $error("src read"); // see [RQ7]
    property p_ptr_step;
        @(posedge core_clk) disable iff (sys_rst || por_rst)
        win_read_ok && !unlock_write |=> rd_ptr == $past(rd_ptr) + AW'(1);
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("ptr no step"); // see [RQ4]
    sequence s_last_line;
        cap_we && !arm_write && valid_line_field == `TBRC_CNT_LAST;
    endsequence
    property p_full_set;
        @(posedge core_clk) disable iff (sys_rst || por_rst)
        s_last_line |=> buffer_full_flag && valid_line_field == 6'h00;
    endproperty
    a_full_set: assert property (p_full_set) else $error("full not set"); // see [RQ14]
    property p_arm_clear;
        @(posedge core_clk) disable iff (sys_rst || por_rst)
        arm_write |=> !buffer_full_flag && valid_line_field == 6'h00;
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("arm no clear"); // see [RQ11]
    property p_begin_end;
        @(posedge core_clk) disable iff (sys_rst || por_rst)
        s_last_line and trig_align |=> !armed;
    endproperty
    a_begin_end: assert property (p_begin_end) else $error("no end"); // see [RQ15]
    property p_no_decr;
        @(posedge core_clk) disable iff (sys_rst || por_rst)
        !cap_we && !arm_write |=> $stable(valid_line_field);
    endproperty
    a_no_decr: assert property (p_no_decr) else $error("count moved"); // see [RQ17]
    property p_secured_src;
        @(posedge core_clk) disable iff (sys_rst || por_rst)
        secured |=> !trace_source_select;
    endproperty
    a_secured_src: assert property (p_secured_src) else $error("src on secured"); // see [RQ22]
    // count register view: full flag on top, count in the low six bits
    property p_count_view;
        @(posedge core_clk) disable iff (sys_rst || por_rst)
        req.rd && hit(req.addr, `TBRC_ADDR_COUNT)
        |=> bus_rdata[7:0] == {$past(buffer_full_flag), 1'b0, $past(valid_line_field)};
    endproperty
    a_count_view: assert property (p_count_view) else $error("count view"); // see [RQ12]
endmodule : tbrc_top

// >>> dv/tb.sv
// self-checking bench for the trace buffer readout, line counter and banked controls
`timescale 1ns/1ps
`include "tbrc_params.svh"
module tb import tbrc_pkg::*;;
    // ****************************************
    // signals and device
    // ****************************************
    logic core_clk;
    logic sys_rst;
    logic por_rst;
    logic [7:0] bus_addr;
    logic [15:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic bus_word;
    logic [15:0] bus_rdata;
    logic cap_valid;
    logic [19:0] cap_data;
    logic [3:0] match_flags;
    logic secured;
    logic armed;
    logic [2:0] seq_state_flags;
    int err_total; // mismatches seen
    int total_checks; // comparisons made

    tbrc_top i_dut (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .por_rst(por_rst),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_word(bus_word),
        .bus_rdata(bus_rdata),
        .cap_valid(cap_valid),
        .cap_data(cap_data),
        .match_flags(match_flags),
        .secured(secured),
        .armed(armed),
        .seq_state_flags(seq_state_flags)
    );

    // 125 MHz system clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ****************************************
    // shared helpers
    // ****************************************
    // trace line pattern, upper nibble differs from line to line
    function automatic logic [19:0] ln(input int i);
        return {4'(i) ^ 4'h5, 16'hB000 + 16'(i)};
    endfunction : ln

    // compare and count; unknowns never pass
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one-cycle word write
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_word <= 1'b1;
        bus_wr <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
    endtask : wr

    // one-cycle read, data taken in the single cycle it stands
    task automatic rchk(input logic [7:0] a, input logic w, input logic [15:0] exp,
                        input logic [15:0] mask = 16'hFFFF);
        @(posedge core_clk);
        bus_addr <= a;
        bus_word <= w;
        bus_rd <= 1'b1;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        @(negedge core_clk);
        chk({4'h0, bus_rdata & mask}, {4'h0, exp & mask});
    endtask : rchk

    // store n trace lines, one pulse each
    task automatic cap(input int first, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge core_clk);
            cap_valid <= 1'b1;
            cap_data <= ln(first + k);
            @(posedge core_clk);
            cap_valid <= 1'b0;
        end
    endtask : cap

    // ****************************************
    // scenarios
    // ****************************************
    // lock, unlock, filtered reads and pointer stepping
    task automatic t_readout;
        wr(`TBRC_ADDR_TRCCTL, 16'h0040);
        wr(`TBRC_ADDR_CTRL1, 16'h0080);
        @(negedge core_clk);
        chk({19'h0, armed}, 20'h1);
        chk({17'h0, seq_state_flags}, 20'h1);
        rchk(`TBRC_ADDR_COUNT, 1'b1, 16'h0000);
        cap(0, 3);
        rchk(`TBRC_ADDR_WIN_HI, 1'b1, 16'h0000);
        rchk(`TBRC_ADDR_COUNT, 1'b1, 16'h0003);
        wr(`TBRC_ADDR_CTRL1, 16'h0000);
        rchk(`TBRC_ADDR_WIN_HI, 1'b1, 16'h0000);
        wr(`TBRC_ADDR_WIN_HI, 16'h1234);
        rchk(`TBRC_ADDR_WIN_HI, 1'b0, 16'h0000);
        rchk(`TBRC_ADDR_WIN_LO, 1'b1, 16'h0000);
        rchk(`TBRC_ADDR_WIN_HI, 1'b1, 16'(ln(0)));
        rchk(`TBRC_ADDR_CAPTURE, 1'b1, 16'(ln(0) >> 16));
        rchk(`TBRC_ADDR_WIN_HI, 1'b1, 16'(ln(1)));
        wr(`TBRC_ADDR_TRCCTL, 16'h0000);
        rchk(`TBRC_ADDR_WIN_HI, 1'b1, 16'h0000);
        wr(`TBRC_ADDR_TRCCTL, 16'h0040);
        rchk(`TBRC_ADDR_WIN_HI, 1'b1, 16'(ln(2)));
        // a fresh unlock must go back to the oldest line, not continue
        wr(`TBRC_ADDR_WIN_HI, 16'h0000);
        rchk(`TBRC_ADDR_WIN_HI, 1'b1, 16'(ln(0)));
        rchk(`TBRC_ADDR_COUNT, 1'b1, 16'h0003);
        rchk(8'h3F, 1'b1, 16'h0000); // unmapped place reads as zero
    endtask : t_readout

    // wrap, overwrite, survival over a system reset, clearing by arming
    task automatic t_full;
        wr(`TBRC_ADDR_CTRL1, 16'h0080);
        cap(100, 64);
        rchk(`TBRC_ADDR_COUNT, 1'b1, 16'h0080);
        rchk(`TBRC_ADDR_STATUS, 1'b1, 16'h0080, 16'h0080);
        cap(164, 1);
        rchk(`TBRC_ADDR_COUNT, 1'b1, 16'h0081);
        wr(`TBRC_ADDR_CTRL1, 16'h0000);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        @(posedge core_clk);
        sys_rst <= 1'b0;
        rchk(`TBRC_ADDR_COUNT, 1'b1, 16'h0081);
        wr(`TBRC_ADDR_TRCCTL, 16'h0040);
        wr(`TBRC_ADDR_WIN_HI, 16'h0000);
        rchk(`TBRC_ADDR_WIN_HI, 1'b1, 16'(ln(101)));
        rchk(`TBRC_ADDR_CAPTURE, 1'b1, 16'(ln(101) >> 16));
        wr(`TBRC_ADDR_CTRL1, 16'h0080);
        rchk(`TBRC_ADDR_COUNT, 1'b1, 16'h0000);
        wr(`TBRC_ADDR_CTRL1, 16'h0000);
    endtask : t_full

    // banked address: three state controls and the match flags
    task automatic t_banked;
        match_flags <= 4'h9;
        for (int s = 0; s < 3; s++) begin
            wr(`TBRC_ADDR_CTRL1, 16'(s));
            wr(`TBRC_ADDR_BANKED, 16'(5 + s));
        end
        // a write while armed must be dropped
        wr(`TBRC_ADDR_CTRL1, 16'h0080);
        wr(`TBRC_ADDR_BANKED, 16'h000F);
        wr(`TBRC_ADDR_CTRL1, 16'h0000);
        for (int s = 0; s < 3; s++) begin
            wr(`TBRC_ADDR_CTRL1, 16'(s));
            rchk(`TBRC_ADDR_BANKED, 1'b1, 16'(5 + s), 16'h000F);
        end
        wr(`TBRC_ADDR_CTRL1, 16'h0003);
        rchk(`TBRC_ADDR_BANKED, 1'b1, 16'h0009, 16'h000F);
    endtask : t_banked

    // begin alignment ends the session at the 64th line
    task automatic t_align;
        wr(`TBRC_ADDR_TRCCTL, 16'h0041);
        wr(`TBRC_ADDR_CTRL1, 16'h0080);
        cap(200, 63);
        @(negedge core_clk);
        chk({19'h0, armed}, 20'h1);
        cap(263, 1);
        @(negedge core_clk);
        chk({19'h0, armed}, 20'h0);
        chk({17'h0, seq_state_flags}, 20'h0);
        rchk(`TBRC_ADDR_COUNT, 1'b1, 16'h0080);
    endtask : t_align

    // secured part, then a power-on reset over a full, non-zero count
    task automatic t_secure_por;
        wr(`TBRC_ADDR_TRCCTL, 16'h0040);
        wr(`TBRC_ADDR_CTRL1, 16'h0080);
        cap(300, 65);
        wr(`TBRC_ADDR_CTRL1, 16'h0000);
        rchk(`TBRC_ADDR_COUNT, 1'b1, 16'h0081);
        @(posedge core_clk);
        secured <= 1'b1;
        wr(`TBRC_ADDR_TRCCTL, 16'h0040);
        rchk(`TBRC_ADDR_TRCCTL, 1'b1, 16'h0000, 16'h0040);
        wr(`TBRC_ADDR_WIN_HI, 16'h0000);
        rchk(`TBRC_ADDR_WIN_HI, 1'b1, 16'h0000);
        @(posedge core_clk);
        secured <= 1'b0;
        sys_rst <= 1'b1;
        por_rst <= 1'b1;
        @(posedge core_clk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        rchk(`TBRC_ADDR_COUNT, 1'b1, 16'h0000);
    endtask : t_secure_por

    // ****************************************
    // run control
    // ****************************************
    task automatic wrap_up;
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    // main sequence, both resets held for three cycles at power-up
    initial begin
        err_total = 0;
        total_checks = 0;
        sys_rst = 1'b1;
        por_rst = 1'b1;
        bus_addr = 8'h00;
        bus_wdata = 16'h0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_word = 1'b0;
        cap_valid = 1'b0;
        cap_data = 20'h00000;
        match_flags = 4'h0;
        secured = 1'b0;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        t_readout();
        t_full();
        t_banked();
        t_align();
        t_secure_por();
        wrap_up();
    end

    // the whole run needs well under 2000 cycles; a hang is cut at 5000
    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        wrap_up();
    end
endmodule : tb
